// [verilog/llc_dead_time_and_bulk_enable.sv]
// Purpose: Gate drive sequencing with adaptive dead time and bulk/line run enable.
// Assumes: All sense inputs are synchronous to ref_clk; on_time_end comes from on-time logic.
// Notes: Every output is registered.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Line below stop threshold starts drop-out timer; run continues until expiry.
// - After a drop-out stop, restart triggers are ignored for a guard time.
// - Bulk hysteresis sink on while bulk_ok low, off while high.
// - During supply rise from reset toward restart level, bulk input pulled low.
// - At restart level, release bulk discharge and enable hysteresis sink.
// - Half-bridge switching allowed only while bulk comparator reports ok.
// - Before start, discharge bridge node until below discharged level.
// - High-side drive inhibited while bootstrap supply under lockout.
// - Two separate swing indications, high-to-low and low-to-high.
// - Matching swing indication ends dead time and turns opposite switch on.
// - Dead time limited to maximum; opposite driver then forced on.
// - Non-faulting option: maximum dead time forces on, no fault.
// - Latching option: maximum dead time latches the converter off.
// - Counter option: fault confirmed after selected number of maximum events.
// - Fixed option: ignore indications, maximum as dead time, no fault.
module llc_dead_time_and_bulk_enable
  import dead_time_pkg::*;
#(
  parameter int DEAD_CYCLES = DEAD_MAX_CYC,
  parameter int DROPOUT_CYCLES = DROPOUT_CYC,
  parameter int GUARD_CYCLES = RESTART_GUARD_CYC,
  parameter logic [FCNT_W-1:0] dead_time_fault_count = FAULT_COUNT_DEF[FCNT_W-1:0]
)(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire sense_s sense,
  input wire dt_option_e dt_option,
  input wire logic on_time_end,
  output drive_s drive
);

  // ****************************************************************
  // Run enable
  // ****************************************************************
  logic [CNT_W-1:0] drop_cnt, next_drop_cnt;
  logic [CNT_W-1:0] guard_cnt, next_guard_cnt;
  logic line_run, next_line_run;
  logic sink, next_sink;
  logic bulk_dis, next_bulk_dis;

  always_comb
  begin
    next_drop_cnt = drop_cnt;
    next_guard_cnt = guard_cnt;
    next_line_run = line_run;
    if (guard_cnt != CNT_ZERO)
    begin
      next_guard_cnt = guard_cnt - CNT_ONE;
    end
    if (line_run)
    begin
      if (sense.line_above_stop)
      begin
        next_drop_cnt = CNT_ZERO;
      end
      else if (drop_cnt + CNT_ONE >= DROPOUT_CYCLES[CNT_W-1:0])
      begin
        next_line_run = 1'b0;
        next_drop_cnt = CNT_ZERO;
        next_guard_cnt = GUARD_CYCLES[CNT_W-1:0];
      end
      else
      begin
        next_drop_cnt = drop_cnt + CNT_ONE;
      end
    end
    else if (sense.line_above_start && guard_cnt == CNT_ZERO)
    begin
      next_line_run = 1'b1;
    end
    if (!sense.supply_above_restart)
    begin
      next_bulk_dis = 1'b1;
      next_sink = 1'b0;
    end
    else
    begin
      next_bulk_dis = 1'b0;
      next_sink = !sense.bulk_ok;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      drop_cnt <= CNT_ZERO;
      guard_cnt <= CNT_ZERO;
      line_run <= 1'b0;
      sink <= 1'b0;
      bulk_dis <= 1'b1;
    end
    else
    begin
      drop_cnt <= next_drop_cnt;
      guard_cnt <= next_guard_cnt;
      line_run <= next_line_run;
      sink <= next_sink;
      bulk_dis <= next_bulk_dis;
    end
  end

  logic run_ok;
  assign run_ok = line_run && sense.bulk_ok && sense.supply_above_restart;

  // ****************************************************************
  // Bridge sequencer
  // ****************************************************************
  bridge_state_e state, next_state;
  logic [CNT_W-1:0] dt_cnt, next_dt_cnt;
  logic [FCNT_W-1:0] fcnt, next_fcnt;
  logic fault, next_fault;
  logic hs, next_hs, ls, next_ls, hb_dis, next_hb_dis;
  logic dead_done, dead_max, swing_seen;

  // A swing indication counts only outside the fixed option.
  function automatic logic swing_counts(input logic seen, input dt_option_e opt);
    return seen && (opt != OPT_FIXED);
  endfunction : swing_counts

  always_comb
  begin
    dead_max = (dt_cnt + CNT_ONE >= DEAD_CYCLES[CNT_W-1:0]);
    swing_seen = (state == ST_DEAD_HL) ? sense.swing_high_to_low
                                       : sense.swing_low_to_high;
    dead_done = dead_max || swing_counts(swing_seen, dt_option);
    next_state = state;
    next_dt_cnt = CNT_ZERO;
    next_fcnt = fcnt;
    next_fault = fault;
    unique case (state)
      ST_INIT:
        if (sense.supply_above_reset)
        begin
          next_state = ST_DISCHARGE;
        end
      ST_DISCHARGE:
        if (sense.bridge_discharged)
        begin
          next_state = ST_IDLE;
        end
      ST_IDLE:
        if (!sense.supply_above_reset)
        begin
          next_state = ST_INIT;
        end
        else if (run_ok && sense.bootstrap_ok)
        begin
          next_state = ST_HIGH;
        end
      ST_HIGH:
        if (!run_ok || !sense.bootstrap_ok || on_time_end)
        begin
          next_state = ST_DEAD_HL;
        end
      ST_LOW:
        if (on_time_end || !run_ok)
        begin
          next_state = run_ok ? ST_DEAD_LH : ST_DISCHARGE;
        end
      ST_DEAD_HL, ST_DEAD_LH:
      begin
        next_dt_cnt = dt_cnt + CNT_ONE;
        if (dead_done)
        begin
          next_dt_cnt = CNT_ZERO;
          if (state == ST_DEAD_HL)
          begin
            next_state = run_ok ? ST_LOW : ST_DISCHARGE;
          end
          else
          begin
            next_state = (run_ok && sense.bootstrap_ok) ? ST_HIGH : ST_IDLE;
          end
          if (dead_max && !swing_counts(swing_seen, dt_option))
          begin
            unique case (dt_option)
              OPT_NO_FAULT, OPT_FIXED: next_fault = fault;
              OPT_LATCH:
              begin
                next_fault = 1'b1;
                next_state = ST_LATCHED;
              end
              OPT_COUNTED:
                if (fcnt + FCNT_ONE >= dead_time_fault_count)
                begin
                  next_fault = 1'b1;
                  next_state = ST_LATCHED;
                end
                else
                begin
                  next_fcnt = fcnt + FCNT_ONE;
                end
            endcase
          end
        end
      end
      ST_LATCHED:
        if (!sense.supply_above_reset)
        begin
          next_state = ST_INIT;
          next_fault = 1'b0;
          next_fcnt = FCNT_ZERO;
        end
    endcase
    next_hs = (next_state == ST_HIGH);
    next_ls = (next_state == ST_LOW);
    next_hb_dis = (next_state == ST_DISCHARGE);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_INIT;
      dt_cnt <= CNT_ZERO;
      fcnt <= FCNT_ZERO;
      fault <= 1'b0;
      hs <= 1'b0;
      ls <= 1'b0;
      hb_dis <= 1'b0;
    end
    else
    begin
      state <= next_state;
      dt_cnt <= next_dt_cnt;
      fcnt <= next_fcnt;
      fault <= next_fault;
      hs <= next_hs;
      ls <= next_ls;
      hb_dis <= next_hb_dis;
    end
  end

  assign drive.high_side_drive = hs;
  assign drive.low_side_drive = ls;
  assign drive.bulk_hysteresis_sink = sink;
  assign drive.bulk_discharge = bulk_dis;
  assign drive.bridge_discharge = hb_dis;
  assign drive.dead_time_fault = fault;
  assign drive.running = line_run;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_no_overlap: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(hs && ls)) else $error("Both drives on.");
  a_dead_after_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(hs) |-> !ls) else $error("Low side on right after high side.");
  a_boot_inhibit: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!sense.bootstrap_ok && hs) |=> !hs) else $error("High side kept under lockout.");
  a_sink_follow: assert property (@(posedge ref_clk) disable iff (!rstn)
    sense.supply_above_restart |=> (sink == !$past(sense.bulk_ok)))
    else $error("Sink does not follow bulk ok.");
  a_bulk_pulldown: assert property (@(posedge ref_clk) disable iff (!rstn)
    !sense.supply_above_restart |=> bulk_dis && !sink) else $error("Bulk not held low.");
  a_bulk_release: assert property (@(posedge ref_clk) disable iff (!rstn)
    sense.supply_above_restart |=> !bulk_dis) else $error("Bulk discharge not released.");
  a_bulk_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(hs) |-> $past(sense.bulk_ok)) else $error("Started without bulk ok.");
  a_dead_clamp: assert property (@(posedge ref_clk) disable iff (!rstn)
    dt_cnt < DEAD_CYCLES[CNT_W-1:0]) else $error("Dead time over maximum.");
  a_fixed_nofault: assert property (@(posedge ref_clk) disable iff (!rstn)
    (dt_option == OPT_FIXED && !fault) |=> !fault) else $error("Fault in fixed option.");
  a_nofault_opt: assert property (@(posedge ref_clk) disable iff (!rstn)
    (dt_option == OPT_NO_FAULT && !fault) |=> !fault) else $error("Fault in plain option.");
  a_discharge_start: assert property (@(posedge ref_clk) disable iff (!rstn)
    (hb_dis && !sense.bridge_discharged) |=> !hs) else $error("Started while charged.");
  a_swing_end: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state == ST_DEAD_HL && sense.swing_high_to_low && dt_option != OPT_FIXED && run_ok)
    |=> ls) else $error("Swing end ignored.");
  a_force_on: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state == ST_DEAD_HL && dead_max && run_ok && dt_option == OPT_NO_FAULT) |=> ls)
    else $error("Opposite drive not forced on.");
  a_fixed_ignore: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state == ST_DEAD_HL && !dead_max && dt_option == OPT_FIXED) |=> !ls)
    else $error("Fixed dead time cut short.");
  a_latch_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    fault |-> !hs && !ls) else $error("Drive on while latched.");
  a_count_confirm: assert property (@(posedge ref_clk) disable iff (!rstn)
    ($rose(fault) && dt_option == OPT_COUNTED)
    |-> ($past(fcnt) + FCNT_ONE >= dead_time_fault_count))
    else $error("Fault before count reached.");
  a_dropout_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    (line_run && !sense.line_above_stop && drop_cnt + CNT_ONE < DROPOUT_CYCLES[CNT_W-1:0])
    |=> line_run) else $error("Run dropped before delay.");
  a_guard_block: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!line_run && guard_cnt != CNT_ZERO) |=> !line_run) else $error("Restart inside guard.");
  c_dead_swing: cover property (@(posedge ref_clk) disable iff (!rstn)
    state == ST_DEAD_HL ##1 ls);
  c_latched: cover property (@(posedge ref_clk) disable iff (!rstn) fault);
  c_dropout_stop: cover property (@(posedge ref_clk) disable iff (!rstn) $fell(line_run));
  c_fixed_dead: cover property (@(posedge ref_clk) disable iff (!rstn)
    dt_option == OPT_FIXED && state == ST_DEAD_HL ##1 ls);
endmodule : llc_dead_time_and_bulk_enable

`default_nettype wire

// [verilog/dead_time_pkg.sv]
// Purpose: Shared constants and types for the half-bridge dead-time and bulk enable block.
// Assumes: 100 MHz reference clock; analog comparators already synchronous to it.
// Notes: Times are kept in their own units; cycle counts derive from them.
package dead_time_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ = 100;
  localparam int DEAD_MAX_NS = 1000;
  localparam int DEAD_MAX_CYC = (DEAD_MAX_NS * CLK_MHZ) / 1000;
  localparam int DROPOUT_US = 60000;
  localparam int DROPOUT_CYC = DROPOUT_US * CLK_MHZ;
  localparam int RESTART_GUARD_US = 1000;
  localparam int RESTART_GUARD_CYC = RESTART_GUARD_US * CLK_MHZ;
  localparam int FAULT_COUNT_DEF = 4;
  localparam int CNT_W = 32;
  localparam int FCNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [FCNT_W-1:0] FCNT_ZERO = 8'h00;
  localparam logic [FCNT_W-1:0] FCNT_ONE = 8'h01;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    OPT_NO_FAULT = 2'h0,
    OPT_LATCH = 2'h1,
    OPT_COUNTED = 2'h2,
    OPT_FIXED = 2'h3
  } dt_option_e;

  typedef enum {ST_INIT, ST_DISCHARGE, ST_IDLE, ST_HIGH, ST_DEAD_HL, ST_LOW, ST_DEAD_LH,
    ST_LATCHED} bridge_state_e;

  typedef struct packed {
    logic supply_above_reset;
    logic supply_above_restart;
    logic bulk_ok;
    logic line_above_stop;
    logic line_above_start;
    logic bridge_discharged;
    logic bootstrap_ok;
    logic swing_high_to_low;
    logic swing_low_to_high;
  } sense_s;

  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
    logic bulk_hysteresis_sink;
    logic bulk_discharge;
    logic bridge_discharge;
    logic dead_time_fault;
    logic running;
  } drive_s;
endpackage : dead_time_pkg

// [sim/bridge_stage_model.sv]
// Purpose: Behavioural half-bridge power stage with its swing sensors.
// Assumes: Drive bits change just after the ref_clk rising edge.
// Notes: swing_on low starves the dead time of its end indication.
`timescale 1ns/1ps
`default_nettype none
module bridge_stage_model
  import dead_time_pkg::*;
(
  input wire logic ref_clk,
  input wire drive_s drive,
  input wire logic swing_on,
  output logic swing_high_to_low,
  output logic swing_low_to_high,
  output logic bridge_discharged
);
  // ****************************************************************
  // Bridge node
  // ****************************************************************
  logic hs_q = 1'b0;
  logic ls_q = 1'b0;
  logic [3:0] node_cnt = 4'h0;
  always_ff @(posedge ref_clk)
  begin
    hs_q <= drive.high_side_drive;
    ls_q <= drive.low_side_drive;
    if (drive.bridge_discharge && !node_cnt[3])
      node_cnt <= node_cnt + 4'h1;
    else if (drive.high_side_drive)
      node_cnt <= 4'h0;
  end
  // The node needs eight cycles of discharge current to settle low.
  assign bridge_discharged = node_cnt[3];
  // Each swing reports for one cycle, in the cycle in which its own switch turns off.
  assign swing_high_to_low = swing_on & hs_q & ~drive.high_side_drive;
  assign swing_low_to_high = swing_on & ls_q & ~drive.low_side_drive;
endmodule : bridge_stage_model
`default_nettype wire

// [sim/tb_top.sv]
// Purpose: Self-checking bench for dead-time sequencing and run enable.
// Assumes: Short drop-out, guard and dead counts set by parameters.
// Notes: Drive vector order is hs, ls, sink, bulk, bridge, fault, run.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dead_time_pkg::*;
;
  localparam int DC = 8;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ote = 1'b0;
  logic swing_on = 1'b1;
  logic h2l;
  logic l2h;
  logic bdis;
  sense_s s_in = '0;
  sense_s sense;
  dt_option_e opt = OPT_NO_FAULT;
  drive_s drive;
  int failures = 0;
  int check_count = 0;
  int n;
  always #5 ref_clk = ~ref_clk;
  always_comb
  begin
    sense = s_in;
    sense.swing_high_to_low = h2l;
    sense.swing_low_to_high = l2h;
    sense.bridge_discharged = bdis;
  end
  llc_dead_time_and_bulk_enable #(.DEAD_CYCLES(DC), .DROPOUT_CYCLES(20), .GUARD_CYCLES(10),
    .dead_time_fault_count(8'h02)) dut_u (.ref_clk(ref_clk), .rstn(rstn), .sense(sense),
    .dt_option(opt), .on_time_end(ote), .drive(drive));
  bridge_stage_model model_u (.ref_clk(ref_clk), .drive(drive), .swing_on(swing_on),
    .swing_high_to_low(h2l), .swing_low_to_high(l2h), .bridge_discharged(bdis));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic until_hs;
    int i = 0;
    while (drive.high_side_drive !== 1'b1 && i < 100)
    begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    check(7'(drive.high_side_drive), 7'h01);
  endtask : until_hs
  // Ends the conduction; cnt is the edge at which the opposite drive is on.
  task automatic dead(input logic to_low, input int lim, output int cnt);
    @(posedge ref_clk);
    ote <= 1'b1;
    @(posedge ref_clk);
    ote <= 1'b0;
    cnt = 1;
    #1;
    while ((to_low ? drive.low_side_drive : drive.high_side_drive) !== 1'b1 && cnt < lim)
    begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
  endtask : dead
  task automatic boot(input dt_option_e o, input logic sw);
    @(posedge ref_clk);
    rstn <= 1'b0;
    opt <= o;
    swing_on <= sw;
    s_in <= 9'h000;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    s_in <= 9'h1F4;
    until_hs();
  endtask : boot
  always @(negedge ref_clk)
    if (rstn)
      check(7'(drive.high_side_drive & drive.low_side_drive), 7'h00);
  initial
  begin
    #100000;
    failures++;
    results();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge ref_clk);
    #1;
    check(drive, 7'h08);
    @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    s_in <= 9'h100;
    repeat (3) @(posedge ref_clk);
    #1;
    check(drive, 7'h0C);
    @(posedge ref_clk);
    s_in <= 9'h180;
    repeat (14) @(posedge ref_clk);
    #1;
    check(drive, 7'h10);
    @(posedge ref_clk);
    s_in <= 9'h1B4;
    repeat (6) @(posedge ref_clk);
    #1;
    check(7'(drive.high_side_drive), 7'h00);
    @(posedge ref_clk);
    s_in <= 9'h1F0;
    repeat (6) @(posedge ref_clk);
    #1;
    check(7'({drive.high_side_drive, drive.bulk_hysteresis_sink}), 7'h00);
    @(posedge ref_clk);
    s_in <= 9'h1F4;
    until_hs();
    dead(1'b1, 200, n);
    check(7'(n), 7'h02);
    dead(1'b0, 200, n);
    check(7'(n), 7'h02);
    @(posedge ref_clk);
    swing_on <= 1'b0;
    dead(1'b1, 200, n);
    check(7'(n), 7'(DC + 1));
    check(7'(drive.dead_time_fault), 7'h00);
    dead(1'b0, 200, n);
    check(7'(n), 7'(DC + 1));
    @(posedge ref_clk);
    s_in <= 9'h1C4;
    repeat (10) @(posedge ref_clk);
    #1;
    check(7'(drive.running), 7'h01);
    @(posedge ref_clk);
    s_in <= 9'h1F4;
    @(posedge ref_clk);
    s_in <= 9'h1C4;
    repeat (22) @(posedge ref_clk);
    #1;
    check(7'(drive.running), 7'h00);
    @(posedge ref_clk);
    s_in <= 9'h1F4;
    repeat (3) @(posedge ref_clk);
    s_in <= 9'h1C4;
    repeat (2) @(posedge ref_clk);
    #1;
    check(7'(drive.running), 7'h00);
    repeat (15) @(posedge ref_clk);
    s_in <= 9'h1F4;
    until_hs();
    @(posedge ref_clk);
    s_in <= 9'h1F0;
    @(posedge ref_clk);
    #1;
    check(7'(drive.high_side_drive), 7'h00);
    boot(OPT_FIXED, 1'b1);
    dead(1'b1, 200, n);
    check(7'(n), 7'(DC + 1));
    check(7'(drive.dead_time_fault), 7'h00);
    boot(OPT_LATCH, 1'b0);
    dead(1'b1, DC + 6, n);
    check(7'({drive.high_side_drive, drive.low_side_drive, drive.dead_time_fault}), 7'h01);
    boot(OPT_COUNTED, 1'b0);
    dead(1'b1, 200, n);
    check(7'({n == DC + 1, drive.dead_time_fault}), 7'h02);
    dead(1'b0, DC + 6, n);
    check(7'({drive.high_side_drive, drive.low_side_drive, drive.dead_time_fault}), 7'h01);
    results();
  end
endmodule : tb_top
`default_nettype wire
